// ### inc/pae_pkg.sv
// Purpose: Shared constants and types for the process alarm evaluator
// Assumes: Signed fixed-point process values, one CLK domain
// Notes: Value scale is 1/256 per unit, so 0.5 is 8'h80 in the fraction
package pae_pkg;
    localparam int PAE_NUM = 6;
    localparam int PAE_VW = 24;
    localparam int PAE_DW = 16;
    localparam int PAE_RW = 8;
    localparam logic signed [PAE_VW-1:0] PAE_HALF = 24'sh000080;
    localparam logic signed [PAE_VW-1:0] PAE_HYST_RST = 24'sh000000;
    // APB map, one 0x20 block per alarm: control, threshold,
    // deviation/rate, hysteresis, delay; then shared reference and status
    localparam logic [11:0] PAE_STRIDE = 12'h020;
    localparam logic [11:0] PAE_OFS_CTRL = 12'h000;
    localparam logic [11:0] PAE_OFS_THR = 12'h004;
    localparam logic [11:0] PAE_OFS_DEV = 12'h008;
    localparam logic [11:0] PAE_OFS_HYS = 12'h00c;
    localparam logic [11:0] PAE_OFS_DLY = 12'h010;
    localparam logic [11:0] PAE_OFS_REF = 12'h100;
    localparam logic [11:0] PAE_OFS_STAT = 12'h104;
    localparam logic [11:0] PAE_OFS_ACK = 12'h108;
    localparam logic [11:0] PAE_OFS_INH = 12'h10c;
    // Control word fields
    localparam int PAE_F_TYPE = 0;
    localparam int PAE_F_LATCH = 4;
    localparam int PAE_F_EN = 8;
    localparam int PAE_CHT_W = 8;
    localparam int PAE_F_CHT = 16;

    typedef enum logic [3:0] {
        PAE_TY_OFF = 4'h0,
        PAE_ABSOLUTE_HIGH_TYPE = 4'h1,
        PAE_ABSOLUTE_LOW_TYPE = 4'h2,
        PAE_DEVIATION_HIGH_TYPE = 4'h3,
        PAE_DEVIATION_LOW_TYPE = 4'h4,
        PAE_DEVIATION_BAND_TYPE = 4'h5,
        PAE_RISE_RATE_TYPE = 4'h6,
        PAE_FALL_RATE_TYPE = 4'h7,
        PAE_DIGITAL_HIGH_TYPE = 4'h8,
        PAE_DIGITAL_LOW_TYPE = 4'h9
    } pae_type_t;

    typedef enum logic [1:0] {
        PAE_LT_NONE = 2'h0,
        PAE_LT_AUTO = 2'h1,
        PAE_LT_MANUAL = 2'h2,
        PAE_LT_EVENT = 2'h3
    } pae_latch_t;

    typedef struct packed {
        pae_type_t kind;
        pae_latch_t latch;
        logic [PAE_CHT_W-1:0] change_time;
        logic signed [PAE_VW-1:0] thr;
        logic signed [PAE_VW-1:0] dev;
        logic signed [PAE_VW-1:0] hys;
        logic [PAE_DW-1:0] delay;
    } pae_cfg_t;

    typedef struct packed {
        logic [PAE_NUM-1:0] output_on;
        logic [PAE_NUM-1:0] status_word;
        logic [PAE_NUM-1:0] unacked;
    } pae_alarm_out_t;
endpackage : pae_pkg

// ### verilog/pae_alarm_unit.sv
// Purpose: One alarm channel: trip/clear, hysteresis, delay, inhibit, latch
// Assumes: sample_en is a one-cycle strobe; all inputs on CLK
// Notes: Rate is taken over change_time samples held in a local history
`timescale 1ns/1ps
`default_nettype none
module pae_alarm_unit
    import pae_pkg::*;
#(
    parameter int HIST = 1 << PAE_CHT_W
)
(
    input wire logic clk,                       // System clock
    input wire logic nrst,                      // Sync reset, active low
    input wire logic sample_en,                 // New sample strobe
    input wire logic signed [PAE_VW-1:0] pv,    // Process value
    input wire logic signed [PAE_VW-1:0] ref_v, // Reference value
    input wire pae_pkg::pae_cfg_t cfg,          // Channel setup
    input wire logic inhibit,                   // Holds alarm off
    input wire logic ack,                       // Acknowledge pulse
    output logic active,                        // Final active state
    output logic working,                       // Active before latching
    output logic unacked                        // Waiting for acknowledge
);
    logic signed [PAE_VW-1:0] hist_mem [HIST];
    logic [PAE_CHT_W-1:0] wr_ptr_r;
    logic [PAE_CHT_W:0] fill_r;
    logic cond_r;
    logic [PAE_DW-1:0] dly_cnt_r;
    logic working_r;
    logic latched_r;
    logic acked_r;
    logic trip;
    logic hold;
    logic cond_nxt;
    logic signed [PAE_VW:0] rate;
    logic signed [PAE_VW-1:0] old_pv;
    logic signed [PAE_VW:0] pv_x;
    logic signed [PAE_VW:0] hi_x;
    logic signed [PAE_VW:0] lo_x;
    logic signed [PAE_VW:0] hys_x;
    logic [PAE_CHT_W-1:0] rd_ptr;

    function automatic logic signed [PAE_VW:0] ext(input logic signed [PAE_VW-1:0] v);
        ext = {v[PAE_VW-1], v};
    endfunction : ext

    assign rd_ptr = wr_ptr_r - cfg.change_time;
    assign old_pv = hist_mem[rd_ptr];
    assign pv_x = ext(pv);
    assign hys_x = ext(cfg.hys);
    assign rate = pv_x - ext(old_pv);

    always_ff @(posedge clk)
    begin
        if (sample_en)
        begin
            hist_mem[wr_ptr_r] <= pv;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wr_ptr_r <= '0;
            fill_r <= '0;
        end
        else if (sample_en)
        begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
            if (fill_r <= {1'b0, cfg.change_time})
            begin
                fill_r <= fill_r + 1'b1;
            end
        end
    end

    always_comb
    begin
        hi_x = '0;
        lo_x = '0;
        trip = 1'b0;
        hold = 1'b0;
        case (cfg.kind)
            PAE_ABSOLUTE_HIGH_TYPE:
            begin
                hi_x = ext(cfg.thr);
                trip = pv_x > hi_x;
                hold = pv_x >= hi_x - hys_x;
            end
            PAE_ABSOLUTE_LOW_TYPE:
            begin
                lo_x = ext(cfg.thr);
                trip = pv_x < lo_x;
                hold = pv_x <= lo_x + hys_x;
            end
            PAE_DEVIATION_HIGH_TYPE:
            begin
                hi_x = ext(ref_v) + ext(cfg.dev);
                trip = pv_x > hi_x;
                hold = pv_x >= hi_x - hys_x;
            end
            PAE_DEVIATION_LOW_TYPE:
            begin
                lo_x = ext(ref_v) - ext(cfg.dev);
                trip = pv_x < lo_x;
                hold = pv_x <= lo_x + hys_x;
            end
            PAE_DEVIATION_BAND_TYPE:
            begin
                hi_x = ext(ref_v) + ext(cfg.dev);
                lo_x = ext(ref_v) - ext(cfg.dev);
                trip = (pv_x > hi_x) || (pv_x < lo_x);
                hold = (pv_x >= hi_x - hys_x) || (pv_x <= lo_x + hys_x);
            end
            PAE_RISE_RATE_TYPE:
            begin
                // No verdict until the history window has filled
                trip = (fill_r > {1'b0, cfg.change_time}) && (rate > ext(cfg.dev));
                hold = trip;
            end
            PAE_FALL_RATE_TYPE:
            begin
                trip = (fill_r > {1'b0, cfg.change_time}) && (-rate > ext(cfg.dev));
                hold = trip;
            end
            PAE_DIGITAL_HIGH_TYPE:
            begin
                trip = pv > PAE_HALF;
                hold = trip;
            end
            PAE_DIGITAL_LOW_TYPE:
            begin
                trip = pv < PAE_HALF;
                hold = trip;
            end
            default:
            begin
                trip = 1'b0;
                hold = 1'b0;
            end
        endcase
        // Zero hysteresis: clear the moment the trip test fails, boundary included
        if (cfg.hys == '0)
        begin
            hold = trip;
        end
        cond_nxt = trip || (cond_r && hold);
    end

    // Condition state with hysteresis, evaluated per sample
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cond_r <= 1'b0;
        end
        else if (sample_en)
        begin
            cond_r <= cond_nxt && !inhibit;
        end
    end

    // Delay counted in samples; restarts when the condition drops
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            dly_cnt_r <= '0;
            working_r <= 1'b0;
        end
        else if (sample_en)
        begin
            if (!cond_nxt || inhibit)
            begin
                dly_cnt_r <= '0;
                working_r <= 1'b0;
            end
            else if (dly_cnt_r >= cfg.delay)
            begin
                working_r <= 1'b1;
            end
            else
            begin
                dly_cnt_r <= dly_cnt_r + 1'b1;
            end
        end
    end

    // Latching stage works on the decided working state
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            latched_r <= 1'b0;
            acked_r <= 1'b0;
        end
        else if (inhibit || cfg.latch == PAE_LT_NONE || cfg.latch == PAE_LT_EVENT)
        begin
            latched_r <= 1'b0;
            acked_r <= 1'b0;
        end
        else if (working_r && !latched_r)
        begin
            latched_r <= 1'b1;
            acked_r <= 1'b0;
        end
        else if (latched_r)
        begin
            // A new trip beats an acknowledge in the same cycle
            if (ack && (cfg.latch == PAE_LT_AUTO || !working_r))
            begin
                acked_r <= 1'b1;
            end
            if ((acked_r || (ack && cfg.latch == PAE_LT_AUTO) ||
                 (ack && !working_r)) && !working_r)
            begin
                latched_r <= 1'b0;
                acked_r <= 1'b0;
            end
        end
    end

    assign working = working_r;
    assign active = working_r || latched_r;
    assign unacked = latched_r && !acked_r;

    a_delay_hold: assert property (@(posedge clk) disable iff (!nrst)
        $rose(working_r) |-> $past(cond_r) || cfg.delay == '0)
        else $error("alarm went active without a prior condition");
    a_inhibit_off: assert property (@(posedge clk) disable iff (!nrst)
        (sample_en && inhibit) |=> !working_r && !cond_r)
        else $error("inhibited alarm became active");
    a_abs_high_trip: assert property (@(posedge clk) disable iff (!nrst)
        (sample_en && !inhibit && cfg.kind == PAE_ABSOLUTE_HIGH_TYPE && pv > cfg.thr)
        |=> cond_r)
        else $error("absolute high did not trip");
    a_abs_low_trip: assert property (@(posedge clk) disable iff (!nrst)
        (sample_en && !inhibit && cfg.kind == PAE_ABSOLUTE_LOW_TYPE && pv < cfg.thr)
        |=> cond_r)
        else $error("absolute low did not trip");
    a_digital_level: assert property (@(posedge clk) disable iff (!nrst)
        (sample_en && !inhibit && cfg.kind == PAE_DIGITAL_HIGH_TYPE) |=> cond_r == ($past(pv) > PAE_HALF))
        else $error("digital high does not follow input");
    a_band_clear: assert property (@(posedge clk) disable iff (!nrst)
        (sample_en && cfg.kind == PAE_DEVIATION_BAND_TYPE && !trip && !hold) |=> !cond_r)
        else $error("band alarm failed to clear inside band");
    a_none_follows: assert property (@(posedge clk) disable iff (!nrst)
        (cfg.latch == PAE_LT_NONE && $stable(cfg.latch)) |=> active == working_r)
        else $error("non latching alarm held its state");
    a_latch_holds: assert property (@(posedge clk) disable iff (!nrst)
        (latched_r && working_r && !inhibit && $stable(cfg.latch)) |=> active)
        else $error("latched alarm dropped while condition present");
endmodule : pae_alarm_unit
`default_nettype wire

// ### verilog/pae_evaluator.sv
// Purpose: Six process alarm channels behind an APB register slave
// Assumes: Single 20 MHz CLK, PV and reference from same-clock logic
// Notes: Inhibit pins are asynchronous and pass a two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Absolute high trips above threshold, clears below threshold minus hysteresis.
// - Absolute low trips under threshold, clears above threshold plus hysteresis.
// - Deviation high trips above reference plus deviation, clears after hysteresis.
// - Deviation low trips below reference minus deviation, clears after hysteresis.
// - Deviation band trips outside reference plus or minus deviation.
// - Deviation band clears only inside band narrowed by hysteresis.
// - Rising rate above maximum trips; clears when it falls below.
// - Falling rate above maximum trips; clears when it falls below.
// - Digital high is active whenever the input is true.
// - Digital low is active whenever the input is false.
// - Hysteresis resets to zero; zero means clear right away.
// - Hysteresis applies only to absolute and deviation types.
// - Activation waits the delay; a dropped condition restarts the timer.
// - Event alarms stay out of the status word and annunciation.
// - Six independent alarm channels.
// - Latching runs as a later stage on the decided state.
// - Each final active state drives an output pin.
// - A high inhibit keeps its alarm inactive.
// - Latch modes none, auto, manual and event.
module pae_evaluator
    import pae_pkg::*;
#(
    parameter int NUM = PAE_NUM
)
(
    input wire logic CLK,                          // 20 MHz clock
    input wire logic NRST,                         // Sync reset, active low
    input wire logic SAMPLE_EN,                    // One-cycle sample strobe
    input wire logic signed [PAE_VW-1:0] PV,       // Process value
    input wire logic [NUM-1:0] INHIBIT,            // Per-alarm inhibit pins
    input wire logic PSEL,                         // APB select
    input wire logic PENABLE,                      // APB enable
    input wire logic PWRITE,                       // APB direction
    input wire logic [11:0] PADDR,                 // APB byte address
    input wire logic [31:0] PWDATA,                // APB write data
    output logic [31:0] PRDATA,                    // APB read data
    output logic PREADY,                           // APB ready
    output logic PSLVERR,                          // APB error
    output pae_pkg::pae_alarm_out_t ALARMS         // Outputs and annunciation
);
    import pae_pkg::*;

    pae_cfg_t cfg_r [NUM];
    logic signed [PAE_VW-1:0] ref_r;
    logic [NUM-1:0] inh_meta_r;
    logic [NUM-1:0] inh_sync_r;
    logic [NUM-1:0] ack_r;
    logic [NUM-1:0] active;
    logic [NUM-1:0] working;
    logic [NUM-1:0] unacked;
    logic [NUM-1:0] is_event;
    logic [31:0] rdata_nxt;
    logic addr_ok;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic apb_wr;
    logic apb_rd;
    logic [11:0] chan_base;
    logic [2:0] chan_idx;
    logic [11:0] chan_ofs;

    // Channel decode: stride is a power of two
    function automatic logic [2:0] chan_of(input logic [11:0] a);
        chan_of = a[7:5];
    endfunction : chan_of

    function automatic logic [31:0] sx(input logic signed [PAE_VW-1:0] v);
        sx = {{(32-PAE_VW){v[PAE_VW-1]}}, v};
    endfunction : sx

    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_rd = PSEL && PENABLE && !PWRITE;
    assign chan_idx = chan_of(PADDR);
    assign chan_base = PADDR & 12'h0e0;
    assign chan_ofs = PADDR - chan_base;

    // Inhibit pins come from outside; first stage read only by the second
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            inh_meta_r <= '0;
            inh_sync_r <= '0;
        end
        else
        begin
            inh_meta_r <= INHIBIT;
            inh_sync_r <= inh_meta_r;
        end
    end

    // Configuration writes
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            ref_r <= '0;
            for (int i = 0; i < NUM; i++)
            begin
                cfg_r[i].kind <= PAE_TY_OFF;
                cfg_r[i].latch <= PAE_LT_NONE;
                cfg_r[i].change_time <= '0;
                cfg_r[i].thr <= '0;
                cfg_r[i].dev <= '0;
                cfg_r[i].hys <= PAE_HYST_RST;
                cfg_r[i].delay <= '0;
            end
        end
        else if (apb_wr && addr_ok)
        begin
            if (PADDR == PAE_OFS_REF)
            begin
                ref_r <= PWDATA[PAE_VW-1:0];
            end
            else if (chan_ofs == PAE_OFS_CTRL)
            begin
                cfg_r[chan_idx].kind <= pae_type_t'(PWDATA[PAE_F_TYPE +: 4]);
                cfg_r[chan_idx].latch <= pae_latch_t'(PWDATA[PAE_F_LATCH +: 2]);
                cfg_r[chan_idx].change_time <= PWDATA[PAE_F_CHT +: PAE_CHT_W];
            end
            else if (chan_ofs == PAE_OFS_THR)
            begin
                cfg_r[chan_idx].thr <= PWDATA[PAE_VW-1:0];
            end
            else if (chan_ofs == PAE_OFS_DEV)
            begin
                cfg_r[chan_idx].dev <= PWDATA[PAE_VW-1:0];
            end
            else if (chan_ofs == PAE_OFS_HYS)
            begin
                cfg_r[chan_idx].hys <= PWDATA[PAE_VW-1:0];
            end
            else if (chan_ofs == PAE_OFS_DLY)
            begin
                cfg_r[chan_idx].delay <= PWDATA[PAE_DW-1:0];
            end
        end
    end

    // Acknowledge is a one-cycle pulse per written bit
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            ack_r <= '0;
        end
        else
        begin
            ack_r <= (apb_wr && PADDR == PAE_OFS_ACK) ? PWDATA[NUM-1:0] : '0;
        end
    end

    always_comb
    begin
        addr_ok = 1'b0;
        rdata_nxt = '0;
        if (PADDR == PAE_OFS_REF)
        begin
            addr_ok = 1'b1;
            rdata_nxt = sx(ref_r);
        end
        else if (PADDR == PAE_OFS_STAT)
        begin
            addr_ok = 1'b1;
            rdata_nxt[NUM-1:0] = ALARMS.status_word;
            rdata_nxt[8 +: NUM] = active;
            rdata_nxt[16 +: NUM] = unacked;
        end
        else if (PADDR == PAE_OFS_ACK)
        begin
            addr_ok = 1'b1;
        end
        else if (PADDR == PAE_OFS_INH)
        begin
            addr_ok = 1'b1;
            rdata_nxt[NUM-1:0] = inh_sync_r;
        end
        else if (chan_idx < 3'(NUM) && PADDR < PAE_OFS_REF)
        begin
            addr_ok = 1'b1;
            if (chan_ofs == PAE_OFS_CTRL)
            begin
                rdata_nxt[PAE_F_TYPE +: 4] = cfg_r[chan_idx].kind;
                rdata_nxt[PAE_F_LATCH +: 2] = cfg_r[chan_idx].latch;
                rdata_nxt[PAE_F_EN] = working[chan_idx];
                rdata_nxt[PAE_F_CHT +: PAE_CHT_W] = cfg_r[chan_idx].change_time;
            end
            else if (chan_ofs == PAE_OFS_THR)
            begin
                rdata_nxt = sx(cfg_r[chan_idx].thr);
            end
            else if (chan_ofs == PAE_OFS_DEV)
            begin
                rdata_nxt = sx(cfg_r[chan_idx].dev);
            end
            else if (chan_ofs == PAE_OFS_HYS)
            begin
                rdata_nxt = sx(cfg_r[chan_idx].hys);
            end
            else if (chan_ofs == PAE_OFS_DLY)
            begin
                rdata_nxt[PAE_DW-1:0] = cfg_r[chan_idx].delay;
            end
            else
            begin
                addr_ok = 1'b0;
            end
        end
    end

    // Read data registered in setup so it is ready in the access phase
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end
        else if (PSEL && !PENABLE)
        begin
            prdata_r <= rdata_nxt;
            pslverr_r <= !addr_ok;
        end
    end

    assign PREADY = 1'b1;
    assign PRDATA = apb_rd ? prdata_r : '0;
    assign PSLVERR = PSEL && PENABLE && pslverr_r;

    for (genvar g = 0; g < NUM; g++)
    begin : g_unit
        pae_alarm_unit u_unit (
            .clk(CLK),
            .nrst(NRST),
            .sample_en(SAMPLE_EN),
            .pv(PV),
            .ref_v(ref_r),
            .cfg(cfg_r[g]),
            .inhibit(inh_sync_r[g]),
            .ack(ack_r[g]),
            .active(active[g]),
            .working(working[g]),
            .unacked(unacked[g])
        );
        assign is_event[g] = cfg_r[g].latch == PAE_LT_EVENT;
    end

    // Outputs from flops so the relay drive never glitches
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            ALARMS <= '0;
        end
        else
        begin
            ALARMS.output_on <= active;
            ALARMS.status_word <= active & ~is_event;
            ALARMS.unacked <= (active | unacked) & ~is_event;
        end
    end

    a_event_hidden: assert property (@(posedge CLK) disable iff (!NRST)
        ##1 ($past(is_event) & ALARMS.status_word) == '0)
        else $error("event alarm appeared in status word");
    a_output_follow: assert property (@(posedge CLK) disable iff (!NRST)
        ##1 ALARMS.output_on == $past(active))
        else $error("output does not follow active state");
endmodule : pae_evaluator
`default_nettype wire

// ### test/pae_pv_src.sv
// Purpose: Process value source feeding the alarm evaluator
// Assumes: Request pulse from the bench, one CLK domain
// Notes: PV holds between samples, as a real transmitter output would
`timescale 1ns/1ps
`default_nettype none
module pae_pv_src
    import pae_pkg::*;
(
    input wire logic CLK,                     // Clock
    input wire logic NRST,                    // Sync reset, active low
    input wire logic req,                     // Take a new sample
    input wire logic signed [PAE_VW-1:0] val, // Value to present
    output logic SAMPLE_EN,                   // One-cycle strobe
    output logic signed [PAE_VW-1:0] PV       // Process value
);
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            SAMPLE_EN <= 1'b0;
            PV <= '0;
        end
        else
        begin
            SAMPLE_EN <= req;
            if (req)
            begin
                PV <= val;
            end
        end
    end
endmodule : pae_pv_src
`default_nettype wire

// ### test/tb.sv
// Purpose: Self-checking bench for the process alarm evaluator
// Assumes: Latch none except a channel 0 latch pass, channel 2 as event
// Notes: PV kept near 0x80 so trips, holds and clears all occur
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pae_pkg::*;
    logic CLK = 0, NRST = 0, req = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic SAMPLE_EN, PREADY, PSLVERR, serr;
    logic signed [PAE_VW-1:0] PV, val = '0;
    logic [5:0] INHIBIT = '0, prev = '0;
    logic [11:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rd, lfsr = 32'hc3e9a43f;
    logic [7:0] ctrl [6] = '{8'h01, 8'h02, 8'h31, 8'h08, 8'h09, 8'h01};
    logic signed [23:0] corner [9] = '{24'sh81, 24'sh80, 24'sh70, 24'sh6f, 24'sh7f,
        24'sh90, 24'sh91, 24'sh91, 24'sh91};
    pae_alarm_out_t ALARMS;
    int err_total = 0, check_count = 0, cnt5 = 0;
    logic [1:0] lmode0 = '0;
    logic lat0 = 0, acked0 = 0;
    pae_evaluator dut_u (.CLK(CLK), .NRST(NRST), .SAMPLE_EN(SAMPLE_EN), .PV(PV),
        .INHIBIT(INHIBIT), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ALARMS(ALARMS));
    pae_pv_src src_u (.CLK(CLK), .NRST(NRST), .req(req), .val(val), .SAMPLE_EN(SAMPLE_EN),
        .PV(PV));
    initial forever #25 CLK = ~CLK;
    // Absolute high with hysteresis; low is the same on negated values
    function automatic logic hi(input logic signed [23:0] p, t, h, input logic was);
        return was ? !(p < t - h) : (p > t);
    endfunction : hi
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic check(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge CLK);
        end
        if (n == 20)
        begin
            err_total++;
            report_and_stop();
        end
        rd = PRDATA;
        serr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask : apb
    // Auto takes an ack any time; manual only once the condition is gone
    task automatic ack_ch0;
        apb(1'b1, PAE_OFS_ACK, 32'h1);
        acked0 = lat0 && (lmode0 == 2'h1 || !prev[0]);
        lat0 = lat0 && !(acked0 && !prev[0]);
        acked0 = acked0 && lat0;
    endtask : ack_ch0
    task automatic sample(input logic signed [23:0] p);
        logic [5:0] c;
        logic [5:0] e;
        val <= p;
        req <= 1'b1;
        @(posedge CLK);
        req <= 1'b0;
        cnt5 = (p > 24'sh80) ? cnt5 + 1 : 0;
        c = {cnt5 > 2, p < 24'sh80, p > 24'sh80, hi(p, 24'sh80, 24'sh10, prev[2]),
            hi(-p, -24'sh80, 24'sh10, prev[1]), hi(p, 24'sh80, 24'sh10, prev[0])};
        c = c & ~INHIBIT;
        if (lmode0 != 2'h0)
        begin
            lat0 = (lat0 | c[0]) & !(acked0 && !c[0]) & !INHIBIT[0];
            acked0 = acked0 & lat0;
        end
        e = c | {5'h0, lat0};
        repeat (4) @(posedge CLK);
        check({26'h0, ALARMS.output_on}, {26'h0, e});
        check({26'h0, ALARMS.status_word}, {26'h0, e & 6'h3b});
        check({26'h0, ALARMS.unacked}, {26'h0, e & 6'h3b});
        prev = c;
    endtask : sample
    initial
    begin
        repeat (6) @(posedge CLK);
        NRST <= 1'b1;
        @(posedge CLK);
        apb(1'b0, PAE_OFS_HYS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h200, 32'h0);
        check({31'h0, serr}, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, 12'(i * 32) + PAE_OFS_THR, 32'h80);
            apb(1'b1, 12'(i * 32) + PAE_OFS_HYS, (i == 5) ? 32'h0 : 32'h10);
            apb(1'b1, 12'(i * 32), {24'h0, ctrl[i]});
        end
        apb(1'b1, 12'ha0 + PAE_OFS_DLY, 32'h2);
        foreach (corner[i])
            sample(corner[i]);
        // Pseudo-random samples around the threshold; each reuses five bits of the last
        repeat (200)
        begin
            lfsr = lfsr_next(lfsr);
            sample(24'sh60 + 24'(lfsr[5:0]));
        end
        // Auto then manual latching on channel 0
        for (int m = 1; m < 3; m++)
        begin
            lmode0 = 2'(m);
            apb(1'b1, PAE_OFS_CTRL, 32'h1 | (32'(m) << PAE_F_LATCH));
            sample(24'sh9f);
            ack_ch0();
            sample(24'sh60);
            sample(24'sh60);
            ack_ch0();
            sample(24'sh60);
        end
        INHIBIT <= 6'h01;
        repeat (4) @(posedge CLK);
        sample(24'sh9f);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
